/* core/pmx_pin_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter and edge pulses.
 * Assumes pins are asynchronous to clk; outputs are registered.
 */
`timescale 1ns/1ns
module pmx_pin_sync #(
    parameter int                WIDTH = 1,
    parameter logic [WIDTH-1:0]  INIT  = '1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } pmx_sync_t;

    localparam pmx_sync_t RESET_ST = '{INIT, INIT, INIT, INIT, '0, '0};

    pmx_sync_t st;
    pmx_sync_t next_st;
    logic [WIDTH-1:0] agree;

    // a change counts only once stages two and three agree
    assign agree = ~(st.s2 ^ st.s3);

    // shift chain, filtered level and one-cycle edge pulses
    always_comb begin
        next_st      = st;
        next_st.s1   = pinIn;
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        next_st.lvl  = (agree & st.s2) | (~agree & st.lvl);
        next_st.rise = next_st.lvl & ~st.lvl;
        next_st.fall = ~next_st.lvl & st.lvl;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;
    assign rise  = st.rise;
    assign fall  = st.fall;

endmodule

/* core/pmx_port_abc_function_mux.sv */
/*
 * Pin function multiplexer for port A bits 7..5, port B and port C bits
 * 2..0. Every pin drive and every signal handed to the core is registered.
 * Assumes all select and peripheral inputs are on clk; pins are not.
 */
`timescale 1ns/1ns
module pmx_port_abc_function_mux (
    input  wire logic       clk,
    input  wire logic       reset,
    // pins, three signals each
    input  wire logic [7:5] portAPinIn,
    output logic      [7:5] portAPinOut,
    output logic      [7:5] portAPinOe,
    input  wire logic [7:0] portBPinIn,
    output logic      [7:0] portBPinOut,
    output logic      [7:0] portBPinOe,
    input  wire logic [2:0] portCPinIn,
    output logic      [2:0] portCPinOut,
    output logic      [2:0] portCPinOe,
    // function selects
    input  wire logic [7:5] portAAltSelect,
    input  wire logic       portAAltSelectSecond,
    input  wire logic [1:0] interfaceConfigField,
    input  wire logic [7:0] portBAltSelect,
    input  wire logic [2:0] portCAltSelect,
    input  wire logic [1:0] portCWaveSelect,
    // port registers and readback
    input  wire logic [7:5] portAOutReg,
    input  wire logic [7:5] portADirReg,
    input  wire logic [7:0] portBOutReg,
    input  wire logic [7:0] portBDirReg,
    input  wire logic [2:0] portCOutReg,
    input  wire logic [2:0] portCDirReg,
    output logic      [7:5] portAIn,
    output logic      [7:0] portBIn,
    output logic      [2:0] portCIn,
    // FIFO, waveform and data bus side
    input  wire logic       extFifoStrobeN,
    output logic            slaveFifoReadStrobe,
    output logic      [2:0] waveReadyIn,
    input  wire logic [7:0] coreDataOut,
    input  wire logic       coreDataOe,
    input  wire logic [7:0] waveADataOut,
    input  wire logic       waveADataOe,
    input  wire logic [7:0] aFifoDataOut,
    input  wire logic       aFifoDataOe,
    output logic      [7:0] portBBusIn,
    // serial ports
    input  wire logic [1:0] serial0Mode,
    input  wire logic       serial0SyncDataOut,
    input  wire logic       serial0ShiftClock,
    input  wire logic       serial0TxData,
    output logic            serial0ReceiveIn,
    input  wire logic [1:0] serial1Mode,
    input  wire logic       serial1SyncDataOut,
    input  wire logic       serial1ShiftClock,
    input  wire logic       serial1TxData,
    output logic            serial1ReceiveIn,
    // timer 2
    input  wire logic       timer2CounterSelect,
    input  wire logic       timer2ExtEnable,
    input  wire logic       timer2Overflow,
    output logic            timer2CountPulse,
    output logic            timer2ReloadPulse,
    // interrupts
    input  wire logic       irq0TypeBit,
    output logic            irq0Request,
    output logic            irq4Request,
    output logic            irq5Request,
    output logic            irq6Request
);

    // all registered state of the mux in one word
    typedef struct packed {
        logic [7:5] aOut;
        logic [7:5] aOe;
        logic [7:0] bOut;
        logic [7:0] bOe;
        logic [2:0] cOut;
        logic [2:0] cOe;
        logic       slaveRd;
        logic [2:0] ready;
        logic [7:0] busIn;
        logic       ser0Rx;
        logic       ser1Rx;
        logic       t2Count;
        logic       t2Reload;
        logic       irq0;
        logic       irq4;
        logic       irq5;
        logic       irq6;
    } pmx_state_t;

    pmx_state_t st;
    pmx_state_t next_st;

    logic [pmx_pkg::SYNC_WIDTH-1:0] syncLevel;
    logic [pmx_pkg::SYNC_WIDTH-1:0] syncRise;
    logic [pmx_pkg::SYNC_WIDTH-1:0] syncFall;
    logic [7:5] aLvl;
    logic [7:0] bLvl;
    logic [7:0] bRise;
    logic [7:0] bFall;
    logic [2:0] cLvl;
    logic [2:0] cFall;
    logic [7:0] bPeriph;
    logic       ser0Sync;
    logic       ser1Sync;

    // every pin passes the three-stage filter before anyone looks at it
    // keeps a metastable first stage away from the edge logic
    pmx_pin_sync #(
        .WIDTH (pmx_pkg::SYNC_WIDTH),
        .INIT  (pmx_pkg::SYNC_RESET)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .pinIn ({portCPinIn, portBPinIn, portAPinIn}),
        .level (syncLevel),
        .rise  (syncRise),
        .fall  (syncFall)
    );

    // slices of the filtered pin vector per port
    assign aLvl  = syncLevel[pmx_pkg::SYNC_A_LSB +: 3];
    assign bLvl  = syncLevel[pmx_pkg::SYNC_B_LSB +: 8];
    assign bRise = syncRise[pmx_pkg::SYNC_B_LSB +: 8];
    assign bFall = syncFall[pmx_pkg::SYNC_B_LSB +: 8];
    assign cLvl  = syncLevel[pmx_pkg::SYNC_C_LSB +: 3];
    assign cFall = syncFall[pmx_pkg::SYNC_C_LSB +: 3];

    // port B core functions only while the bus is not claimed
    assign bPeriph = portBAltSelect
                   & {8{interfaceConfigField == pmx_pkg::IFC_PORTS}};
    // serial mode decode shared by the transmit and sync data paths
    assign ser0Sync = (serial0Mode == pmx_pkg::SERIAL_MODE_SYNC);
    assign ser1Sync = (serial1Mode == pmx_pkg::SERIAL_MODE_SYNC);

    // function selection for all pins, registered below
    always_comb begin
        next_st          = '0;
        next_st.ser0Rx   = 1'b1;
        next_st.ser1Rx   = 1'b1;
        // port function by default: port registers drive the pin
        next_st.aOut     = portAOutReg;
        next_st.aOe      = portADirReg;
        next_st.cOut     = portCOutReg;
        next_st.cOe      = portCDirReg;

        // second select with field 0 or 1 falls back to the port function;
        // the strobe idles as an input out of reset, so the board pull
        // keeps it inactive until a function is chosen
        // port A bit 5: strobe out, ready in, slave strobe in
        if (portAAltSelect[pmx_pkg::PA_FIFO_STROBE]) begin
            if (!portAAltSelectSecond) begin
                next_st.aOut[pmx_pkg::PA_FIFO_STROBE] = extFifoStrobeN;
                next_st.aOe[pmx_pkg::PA_FIFO_STROBE]  = 1'b1;
            end else if (interfaceConfigField == pmx_pkg::IFC_WAVE) begin
                next_st.aOe[pmx_pkg::PA_FIFO_STROBE] = 1'b0;
                next_st.ready[2] = aLvl[pmx_pkg::PA_FIFO_STROBE];
            end else if (interfaceConfigField == pmx_pkg::IFC_SLAVE) begin
                next_st.aOe[pmx_pkg::PA_FIFO_STROBE] = 1'b0;
                next_st.slaveRd = aLvl[pmx_pkg::PA_FIFO_STROBE];
            end
        end

        // outside the synchronous mode the line parks at its idle level
        // port A bits 6 and 7: serial sync data, idle high otherwise
        if (portAAltSelect[pmx_pkg::PA_SER0_SYNC]) begin
            next_st.aOut[pmx_pkg::PA_SER0_SYNC] =
                ser0Sync ? serial0SyncDataOut : 1'b1;
            next_st.aOe[pmx_pkg::PA_SER0_SYNC] = 1'b1;
        end
        if (portAAltSelect[pmx_pkg::PA_SER1_SYNC]) begin
            next_st.aOut[pmx_pkg::PA_SER1_SYNC] =
                ser1Sync ? serial1SyncDataOut : 1'b1;
            next_st.aOe[pmx_pkg::PA_SER1_SYNC] = 1'b1;
        end

        // a claimed bus hands all eight pins to one owner and turns
        // the port B alternate functions off
        // port B data bus owner chosen by the configuration field
        case (interfaceConfigField)
            pmx_pkg::IFC_BUS: begin
                next_st.bOut = coreDataOut;
                next_st.bOe  = {8{coreDataOe}};
            end
            pmx_pkg::IFC_WAVE: begin
                next_st.bOut = waveADataOut;
                next_st.bOe  = {8{waveADataOe}};
            end
            pmx_pkg::IFC_SLAVE: begin
                next_st.bOut = aFifoDataOut;
                next_st.bOe  = {8{aFifoDataOe}};
            end
            default: begin
                next_st.bOut = portBOutReg;
                next_st.bOe  = portBDirReg & ~bPeriph;
            end
        endcase
        if (interfaceConfigField != pmx_pkg::IFC_PORTS) begin
            next_st.busIn = bLvl;
        end

        // port B core peripheral outputs
        if (bPeriph[pmx_pkg::PB_SER1_TX]) begin
            next_st.bOut[pmx_pkg::PB_SER1_TX] =
                ser1Sync ? serial1ShiftClock : serial1TxData;
            next_st.bOe[pmx_pkg::PB_SER1_TX] = 1'b1;
        end
        if (bPeriph[pmx_pkg::PB_T2_OVF]) begin
            next_st.bOut[pmx_pkg::PB_T2_OVF] = timer2Overflow;
            next_st.bOe[pmx_pkg::PB_T2_OVF]  = 1'b1;
        end

        // counter and reload use falling edges only, so a level held
        // on either pin gives no further pulses
        // port B core peripheral inputs
        next_st.t2Count  = bPeriph[pmx_pkg::PB_T2_CLOCK]
                         & timer2CounterSelect
                         & bFall[pmx_pkg::PB_T2_CLOCK];
        next_st.t2Reload = bPeriph[pmx_pkg::PB_T2_RELOAD]
                         & timer2ExtEnable
                         & bFall[pmx_pkg::PB_T2_RELOAD];
        if (bPeriph[pmx_pkg::PB_SER1_RX]) begin
            next_st.ser1Rx = bLvl[pmx_pkg::PB_SER1_RX];
        end
        next_st.irq4 = bPeriph[pmx_pkg::PB_IRQ4]
                     & bRise[pmx_pkg::PB_IRQ4];
        next_st.irq5 = bPeriph[pmx_pkg::PB_IRQ5]
                     & bFall[pmx_pkg::PB_IRQ5];
        next_st.irq6 = bPeriph[pmx_pkg::PB_IRQ6]
                     & bRise[pmx_pkg::PB_IRQ6];

        // port C bit 0: ready input wins over serial 0 receive
        if (portCWaveSelect[pmx_pkg::PC_SER0_RX]) begin
            next_st.cOe[pmx_pkg::PC_SER0_RX] = 1'b0;
            next_st.ready[0] = cLvl[pmx_pkg::PC_SER0_RX];
        end else if (portCAltSelect[pmx_pkg::PC_SER0_RX]) begin
            next_st.cOe[pmx_pkg::PC_SER0_RX] = 1'b0;
            next_st.ser0Rx = cLvl[pmx_pkg::PC_SER0_RX];
        end

        // port C bit 1: ready input wins over serial 0 transmit
        if (portCWaveSelect[pmx_pkg::PC_SER0_TX]) begin
            next_st.cOe[pmx_pkg::PC_SER0_TX] = 1'b0;
            next_st.ready[1] = cLvl[pmx_pkg::PC_SER0_TX];
        end else if (portCAltSelect[pmx_pkg::PC_SER0_TX]) begin
            next_st.cOut[pmx_pkg::PC_SER0_TX] =
                ser0Sync ? serial0ShiftClock : serial0TxData;
            next_st.cOe[pmx_pkg::PC_SER0_TX] = 1'b1;
        end

        // level mode keeps requesting for as long as the pin stays low
        // port C bit 2: interrupt 0, falling edge or low level
        if (portCAltSelect[pmx_pkg::PC_IRQ0]) begin
            next_st.cOe[pmx_pkg::PC_IRQ0] = 1'b0;
            next_st.irq0 = irq0TypeBit ? cFall[pmx_pkg::PC_IRQ0]
                                       : ~cLvl[pmx_pkg::PC_IRQ0];
        end
    end

    // reset leaves every pin an input, so nothing drives a line
    // before a function has been chosen
    // one register stage: selects reach the pins at the next edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st      <= '0;
            st.aOe  <= {3{pmx_pkg::PIN_OE_RESET}};
            st.bOe  <= {8{pmx_pkg::PIN_OE_RESET}};
            st.cOe  <= {3{pmx_pkg::PIN_OE_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flip-flops
    assign portAPinOut         = st.aOut;
    assign portAPinOe          = st.aOe;
    assign portBPinOut         = st.bOut;
    assign portBPinOe          = st.bOe;
    assign portCPinOut         = st.cOut;
    assign portCPinOe          = st.cOe;
    assign slaveFifoReadStrobe = st.slaveRd;
    assign waveReadyIn         = st.ready;
    assign portBBusIn          = st.busIn;
    assign serial0ReceiveIn    = st.ser0Rx;
    assign serial1ReceiveIn    = st.ser1Rx;
    assign timer2CountPulse    = st.t2Count;
    assign timer2ReloadPulse   = st.t2Reload;
    assign irq0Request         = st.irq0;
    assign irq4Request         = st.irq4;
    assign irq5Request         = st.irq5;
    assign irq6Request         = st.irq6;

    // readback skips the output stage, so it shows the pin itself
    // even while another function owns it
    // port readback is the filtered pin level in every function
    assign portAIn = aLvl;
    assign portBIn = bLvl;
    assign portCIn = cLvl;

endmodule

/* dv/pmx_mux_properties.sv */
/* Concurrent checks on the pin function mux ports.
   Assumes binding to the top module; one clock, reset async high. */
`timescale 1ns/1ns
module pmx_mux_properties (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [7:5] portAPinOut,
    input wire logic [7:5] portAPinOe,
    input wire logic [7:0] portBPinOut,
    input wire logic [7:0] portBIn,
    input wire logic [7:5] portAAltSelect,
    input wire logic       portAAltSelectSecond,
    input wire logic [1:0] interfaceConfigField,
    input wire logic [7:0] portBAltSelect,
    input wire logic [7:5] portAOutReg,
    input wire logic [7:5] portADirReg,
    input wire logic       extFifoStrobeN,
    input wire logic [1:0] serial0Mode,
    input wire logic       serial0SyncDataOut,
    input wire logic [1:0] serial1Mode,
    input wire logic       serial1SyncDataOut,
    input wire logic       timer2CounterSelect,
    input wire logic       timer2Overflow,
    input wire logic       timer2CountPulse,
    input wire logic       irq4Request,
    input wire logic       irq5Request
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic ifcPorts;

    // port-only configuration
    assign ifcPorts = interfaceConfigField == pmx_pkg::IFC_PORTS;

    a_port_bit_drive: assert property (
        !portAAltSelect[5] |=> portAPinOe[5] == $past(portADirReg[5])
        && portAPinOut[5] == $past(portAOutReg[5]))
        else $error("port bit drive on A5 wrong");
    a_fifo_strobe_out: assert property (
        portAAltSelect[5] && !portAAltSelectSecond |=> portAPinOe[5]
        && portAPinOut[5] == $past(extFifoStrobeN))
        else $error("strobe drive on A5 wrong");
    a_ser0_sync_out: assert property (
        portAAltSelect[6] |=> portAPinOut[6] == ($past(serial0Mode)
        == pmx_pkg::SERIAL_MODE_SYNC ? $past(serial0SyncDataOut) : 1'b1))
        else $error("serial 0 data on A6 wrong");
    a_ser1_sync_out: assert property (
        portAAltSelect[7] |=> portAPinOut[7] == ($past(serial1Mode)
        == pmx_pkg::SERIAL_MODE_SYNC ? $past(serial1SyncDataOut) : 1'b1))
        else $error("serial 1 data on A7 wrong");
    a_ovf_pulse_out: assert property (
        portBAltSelect[7] && ifcPorts
        |=> portBPinOut[7] == $past(timer2Overflow))
        else $error("overflow output on B7 wrong");
    a_irq4_rise_one: assert property (
        irq4Request |-> portBAltSelect[4] && ifcPorts && portBIn[4]
        ##1 !irq4Request)
        else $error("interrupt 4 request wrong");
    a_irq5_fall_one: assert property (
        irq5Request |-> portBAltSelect[5] && !portBIn[5] ##1 !irq5Request)
        else $error("interrupt 5 request wrong");
    a_count_gate: assert property (
        timer2CountPulse |-> timer2CounterSelect && !portBIn[0])
        else $error("timer 2 count without counter mode");

    c_irq4: cover property (irq4Request);
    c_count: cover property (timer2CountPulse);
    c_ovf: cover property (portBAltSelect[7] && timer2Overflow);
endmodule

bind pmx_port_abc_function_mux pmx_mux_properties pmx_mux_properties_i (.*);

/* dv/pmx_pin_partner.sv */
/* Far side of the pins: board pulls, external drivers, floating lines.
   Assumes one clock; device drive wins, then the far side's drive. */
`timescale 1ns/1ns
module pmx_pin_partner #(
    parameter int           W    = 8,
    parameter logic [W-1:0] PULL = '0
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] devOut,
    input  wire logic [W-1:0] devOe,
    input  wire logic [W-1:0] extOe,
    input  wire logic [W-1:0] extVal,
    output logic      [W-1:0] level
);
    logic [W-1:0] wobble = '0;

    // floating lines without a pull change every cycle
    always @(posedge clk) begin
        wobble <= ~wobble;
    end

    // resolve each line from all parties
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (devOe[i])
                level[i] = devOut[i];
            else if (extOe[i])
                level[i] = extVal[i];
            else
                level[i] = PULL[i] | wobble[i];
        end
    end
endmodule

/* dv/pmx_port_abc_function_mux_tb.sv */
/* Self-checking bench of the pin function mux with a pin partner.
   Assumes the package constants; inputs change 2 ns after each edge. */
`timescale 1ns/1ns
module pmx_port_abc_function_mux_tb;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:5] portAPinIn, portAPinOut, portAPinOe, portAAltSelect;
    logic [7:5] portAOutReg, portADirReg, portAIn, extOeA, extValA;
    logic [7:0] portBPinIn, portBPinOut, portBPinOe, portBAltSelect;
    logic [7:0] portBOutReg, portBDirReg, portBIn, portBBusIn;
    logic [7:0] coreDataOut, waveADataOut, aFifoDataOut, extOeB, extValB;
    logic [2:0] portCPinIn, portCPinOut, portCPinOe, portCAltSelect;
    logic [2:0] portCOutReg, portCDirReg, portCIn, waveReadyIn;
    logic [2:0] extOeC, extValC;
    logic [1:0] interfaceConfigField, portCWaveSelect;
    logic [1:0] serial0Mode, serial1Mode;
    logic       portAAltSelectSecond, extFifoStrobeN, slaveFifoReadStrobe;
    logic       coreDataOe, waveADataOe, aFifoDataOe;
    logic       serial0SyncDataOut, serial0ShiftClock, serial0TxData;
    logic       serial1SyncDataOut, serial1ShiftClock, serial1TxData;
    logic       serial0ReceiveIn, serial1ReceiveIn, irq0TypeBit;
    logic       timer2CounterSelect, timer2ExtEnable, timer2Overflow;
    logic       timer2CountPulse, timer2ReloadPulse, irq0Request;
    logic       irq4Request, irq5Request, irq6Request;
    int         n_errors = 0;
    int         checks = 0;

    pmx_port_abc_function_mux pmx_port_abc_function_mux_i (.*);
    pmx_pin_partner #(.W(3), .PULL(3'h1)) pmx_pin_partner_a_i (.clk,
        .devOut(portAPinOut), .devOe(portAPinOe), .extOe(extOeA),
        .extVal(extValA), .level(portAPinIn));
    pmx_pin_partner #(.W(8)) pmx_pin_partner_b_i (.clk, .devOut(portBPinOut),
        .devOe(portBPinOe), .extOe(extOeB), .extVal(extValB),
        .level(portBPinIn));
    pmx_pin_partner #(.W(3)) pmx_pin_partner_c_i (.clk, .devOut(portCPinOut),
        .devOe(portCPinOe), .extOe(extOeC), .extVal(extValC),
        .level(portCPinIn));

    // free-running core clock
    always #10 clk = ~clk;

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // moves one pin (C pins at 8 and up) and counts pulses of one output
    task automatic edge_run(input int pin, input logic lvl, input int sel,
                            input logic [7:0] exp);
        logic [5:0] hits;
        int         cnt;
        cnt = 0;
        if (pin > 7)
            extValC[pin-8] = lvl;
        else
            extValB[pin] = lvl;
        repeat (10) begin
            step(1);
            hits = {irq0Request, irq6Request, irq5Request, irq4Request,
                    timer2ReloadPulse, timer2CountPulse};
            cnt += int'(hits[sel]);
        end
        cmp(8'(cnt), exp);
    endtask

    task automatic port_a_functions;
        {portAAltSelect, extFifoStrobeN} = 4'he;
        for (int m = 0; m < 4; m++) begin
            {serial0Mode, serial1Mode} = {2'(m), 2'(m)};
            step(2);
            cmp({5'h0, portAPinOut}, (m == 0) ? 8'h00 : 8'h06);
            cmp({5'h0, portAPinOe}, 8'h07);
        end
        {portAAltSelectSecond, extOeA, extValA} = 7'h7f;
        for (int f = 0; f < 4; f++) begin
            interfaceConfigField = 2'(f);
            step(6);
            cmp({6'h0, waveReadyIn[2], slaveFifoReadStrobe},
                8'(f == 2 ? 2 : f == 3 ? 1 : 0));
        end
        {portAAltSelect, portAAltSelectSecond, extOeA} = 7'h0;
        interfaceConfigField = 2'h0;
    endtask

    task automatic port_b_bus;
        {portBDirReg, portBOutReg} = 16'hffa5;
        {portCDirReg, portCOutReg} = 6'h3d;
        step(2);
        cmp(portBPinOut, 8'ha5);
        cmp(portBPinOe, 8'hff);
        cmp({2'h0, portCPinOe, portCPinOut}, 8'h3d);
        {coreDataOe, waveADataOe, aFifoDataOe} = 3'h7;
        for (int f = 1; f < 4; f++) begin
            interfaceConfigField = 2'(f);
            step(2);
            cmp(portBPinOut, 8'(f * 17));
            cmp(portBPinOe, 8'hff);
        end
        {coreDataOe, waveADataOe, aFifoDataOe} = 3'h0;
        {extOeB, extValB} = 16'hff5a;
        step(6);
        cmp(portBBusIn, 8'h5a);
        cmp(portBIn, 8'h5a);
        {interfaceConfigField, portBDirReg, extValB} = 18'h23;
        portCDirReg = 3'h0;
    endtask

    task automatic events_and_serial;
        {portBAltSelect, timer2CounterSelect, timer2ExtEnable} = 10'h3ff;
        {portCAltSelect, extOeC, extValC} = 9'h1fc;
        step(6);
        edge_run(0, 1'b0, 0, 8'h1);
        edge_run(0, 1'b1, 0, 8'h0);
        edge_run(1, 1'b0, 1, 8'h1);
        edge_run(1, 1'b1, 1, 8'h0);
        edge_run(4, 1'b1, 2, 8'h1);
        edge_run(4, 1'b0, 2, 8'h0);
        edge_run(5, 1'b0, 3, 8'h1);
        edge_run(5, 1'b1, 3, 8'h0);
        edge_run(6, 1'b1, 4, 8'h1);
        edge_run(6, 1'b0, 4, 8'h0);
        {timer2CounterSelect, timer2ExtEnable} = 2'h0;
        edge_run(0, 1'b0, 0, 8'h0);
        edge_run(1, 1'b0, 1, 8'h0);
        edge_run(10, 1'b0, 5, 8'h1);
        edge_run(10, 1'b1, 5, 8'h0);
        irq0TypeBit = 1'b0;
        edge_run(10, 1'b0, 5, 8'h6);
        timer2Overflow = 1'b1;
        step(1);
        timer2Overflow = 1'b0;
        cmp(8'(portBPinOut[7]), 8'h1);
        step(1);
        cmp(8'(portBPinOut[7]), 8'h0);
        {serial0ShiftClock, serial0TxData} = 2'h2;
        {serial1ShiftClock, serial1TxData} = 2'h2;
        for (int m = 0; m < 4; m++) begin
            {serial0Mode, serial1Mode} = {2'(m), 2'(m)};
            {extValC[0], extValB[2]} = {2{m[0]}};
            step(6);
            cmp({6'h0, portCPinOut[1], portBPinOut[3]},
                (m == 0) ? 8'h3 : 8'h0);
            cmp({6'h0, serial0ReceiveIn, serial1ReceiveIn},
                8'({2{m[0]}}));
        end
        {portCWaveSelect, extValC[1:0]} = 4'he;
        step(6);
        cmp({6'h0, waveReadyIn[1:0]}, 8'h2);
        cmp({5'h0, portCIn}, 8'h2);
    endtask

    // stimulus: all inputs quiet, reset, then each scenario
    initial begin
        {portAAltSelect, portAAltSelectSecond, interfaceConfigField} = 6'h0;
        {portBAltSelect, portCAltSelect, portCWaveSelect} = 13'h0;
        {portAOutReg, portADirReg, portBOutReg, portBDirReg} = 22'h0;
        {portCOutReg, portCDirReg, extOeA, extValA, extOeC, extValC} = 18'h0;
        {coreDataOut, waveADataOut, aFifoDataOut} = 24'h112233;
        {coreDataOe, waveADataOe, aFifoDataOe, extFifoStrobeN} = 4'h1;
        {extOeB, extValB, serial0Mode, serial1Mode} = 20'h0;
        {serial0SyncDataOut, serial0ShiftClock, serial0TxData} = 3'h0;
        {serial1SyncDataOut, serial1ShiftClock, serial1TxData} = 3'h0;
        {timer2CounterSelect, timer2ExtEnable, timer2Overflow} = 3'h0;
        irq0TypeBit = 1'b1;
        repeat (10) @(posedge clk);
        #2 reset = 1'b0;
        step(5);
        cmp({2'h0, portAPinOe, portCPinOe}, 8'h00);
        cmp(8'(portAIn[5]), 8'h1);
        port_a_functions();
        port_b_bus();
        events_and_serial();
        complete_run();
    end
endmodule

/* pkg/pmx_pkg.sv */
/*
 * Shared constants of the port A/B/C pin function multiplexer: interface
 * configuration codes, serial mode codes, pin positions and reset values.
 * Assumes one core clock domain; the pins arrive unsynchronised.
 */
// How it works
// - port A bit 5 function from three selects
// - slave strobe in; external FIFO strobe out
// - port A bit 5 stays input after reset
// - bit A6: serial 0 sync data, else high
// - bit A7: serial 1 sync data, else high
// - port B bit n by select and configuration
// - timer 2 counts pin only when counter selected
// - trigger falling edge reloads timer 2 if enabled
// - serial 1 receive taken in every mode
// - serial 1 transmit: clock sync, data async
// - interrupt 4 on rising edge
// - interrupt 5 on falling edge
// - interrupt 6 on rising edge
// - overflow output high one cycle per overflow
// - port C bits 0/1 by two selects
// - serial 0 receive in; transmit clock or data
// - bit C2: interrupt 0, edge or level
package pmx_pkg;

    // interface configuration field codes
    localparam logic [1:0] IFC_PORTS = 2'h0;
    localparam logic [1:0] IFC_BUS   = 2'h1;
    localparam logic [1:0] IFC_WAVE  = 2'h2;
    localparam logic [1:0] IFC_SLAVE = 2'h3;

    // serial mode that runs the synchronous shift register
    localparam logic [1:0] SERIAL_MODE_SYNC = 2'h0;

    // layout of the synchroniser vector: A[7:5], B[7:0], C[2:0]
    localparam int SYNC_WIDTH = 14;
    localparam int SYNC_A_LSB = 0;
    localparam int SYNC_B_LSB = 3;
    localparam int SYNC_C_LSB = 11;

    // pin positions of the alternate functions
    localparam int PA_FIFO_STROBE = 5;
    localparam int PA_SER0_SYNC   = 6;
    localparam int PA_SER1_SYNC   = 7;
    localparam int PB_T2_CLOCK    = 0;
    localparam int PB_T2_RELOAD   = 1;
    localparam int PB_SER1_RX     = 2;
    localparam int PB_SER1_TX     = 3;
    localparam int PB_IRQ4        = 4;
    localparam int PB_IRQ5        = 5;
    localparam int PB_IRQ6        = 6;
    localparam int PB_T2_OVF      = 7;
    localparam int PC_SER0_RX     = 0;
    localparam int PC_SER0_TX     = 1;
    localparam int PC_IRQ0        = 2;

    // reset values: pins idle as inputs, filtered levels idle high
    localparam logic             PIN_OE_RESET  = 1'h0;
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 14'h3fff;

endpackage
